// ---- verilog/lrr_pkg.sv ----
// constants and carrier types for the logic, rotate and return execute slice
package lrr_pkg;

  // primary and extended opcodes
  localparam logic [5:0] OPC_X      = 6'h1f;
  localparam logic [9:0] XO_ORC     = 10'h19c;
  localparam logic [5:0] OPC_ORI    = 6'h18;
  localparam logic [5:0] OPC_ORIS   = 6'h19;
  localparam logic [5:0] OPC_XL     = 6'h13;
  localparam logic [9:0] XO_RFI     = 10'h032;
  localparam logic [5:0] OPC_RLD    = 6'h1e;
  localparam logic [2:0] SUB_RLDICL = 3'h0;
  localparam logic [2:0] SUB_RLDICR = 3'h1;
  localparam logic [2:0] SUB_RLDIMI = 3'h3;

  // field positions, little-endian indices of big-endian fields
  localparam int OPC_LSB = 26;
  localparam int RS_LSB  = 21;
  localparam int RA_LSB  = 16;
  localparam int RB_LSB  = 11;
  localparam int XO_LSB  = 1;
  localparam int SUB_LSB = 2;
  localparam int SH5_POS = 1;
  localparam int MB5_POS = 5;
  localparam int MB_LSB  = 6;
  localparam int RC_POS  = 0;

  // machine state bits, interrupt classes and masks
  localparam int          WAIT_ENABLE_BIT_POS = 18;
  localparam int          NIRQ       = 4;
  localparam logic [31:0] GPR_DEF    = 32'hffffffff;
  localparam logic [63:0] ONES64     = 64'hffffffffffffffff;
  localparam logic [31:0] IAR_MASK   = 32'hfffffffc;
  localparam logic [NIRQ-1:0][4:0] IRQ_EN_POS = {5'h10, 5'h10, 5'h13, 5'h1f};

  typedef enum logic [2:0] {
    OP_NONE, OP_ORC, OP_ORI, OP_ORIS, OP_RFI, OP_RLDICL, OP_RLDICR, OP_RLDIMI
  } lrr_op_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] instr;
    logic [31:0] src;
    logic [31:0] src2;
    logic [63:0] src_pair;
    logic [63:0] dst_pair;
  } lrr_req_t;

  typedef struct packed {
    logic        gpr_we;
    logic [4:0]  gpr_idx;
    logic [31:0] gpr_data;
    logic        pair_we;
    logic [4:0]  pair_idx;
    logic [63:0] pair_data;
    logic        cr0_we;
    logic [3:0]  cr0;
    logic        iar_we;
    logic [31:0] instruction_address_reg;
    logic        wait_enable_bit;
    logic [31:0] machine_state_reg;
    logic        save_restore_addr_we;
    logic [31:0] save_restore_addr;
    logic        save_restore_state_we;
    logic [31:0] save_restore_state;
    logic        int_take;
    logic [1:0]  int_idx;
    logic        wait_enter;
    logic        fetch;
    logic [31:0] fetch_addr;
    logic        ctx_sync;
    logic        illegal;
  } lrr_res_t;

  typedef struct packed {
    lrr_op_t  op;
    lrr_res_t res;
  } lrr_st_t;

endpackage

// ---- verilog/lrr_exec.sv ----
// execute stage for or-complement, or-immediate, return and doubleword rotates
`timescale 1ns/1ps
module lrr_exec import lrr_pkg::*; (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // core variant and debug status
  input  wire logic        ext_core,
  input  wire logic        halted,
  input  wire logic        rammed,
  // architected state feeding this slice
  input  wire logic        xer_so,
  input  wire logic [31:0] srr_addr_in,
  input  wire logic [31:0] srr_state_in,
  input  wire logic [3:0]  irq_pend,
  // instruction with its operands
  input  wire lrr_req_t    req,
  // registered results
  output lrr_res_t         res
);

  lrr_st_t st_r;
  lrr_st_t st_nxt;

  function automatic lrr_op_t decode(logic [31:0] i);
    lrr_op_t  op;
    logic [2:0] sub;
    op  = OP_NONE;
    sub = i[SUB_LSB +: 3];
    if (i[OPC_LSB +: 6] == OPC_X && i[XO_LSB +: 10] == XO_ORC) begin
      op = OP_ORC;
    end else if (i[OPC_LSB +: 6] == OPC_ORI) begin
      op = OP_ORI;
    end else if (i[OPC_LSB +: 6] == OPC_ORIS) begin
      op = OP_ORIS;
    end else if (i[OPC_LSB +: 6] == OPC_XL && i[XO_LSB +: 10] == XO_RFI) begin
      op = OP_RFI;
    end else if (i[OPC_LSB +: 6] == OPC_RLD && sub == SUB_RLDICL) begin
      op = OP_RLDICL;
    end else if (i[OPC_LSB +: 6] == OPC_RLD && sub == SUB_RLDICR) begin
      op = OP_RLDICR;
    end else if (i[OPC_LSB +: 6] == OPC_RLD && sub == SUB_RLDIMI) begin
      op = OP_RLDIMI;
    end
    return op;
  endfunction

  // big-endian numbering: position p is little-endian bit 63-p
  function automatic logic [63:0] mask64(logic [5:0] b, logic [5:0] e);
    logic [63:0] hi;
    logic [63:0] lo;
    hi = ONES64 >> b;
    lo = ~((ONES64 >> e) >> 1);
    return (b <= e) ? (hi & lo) : (hi | lo);
  endfunction

  function automatic logic [63:0] rotl64(logic [63:0] x, logic [5:0] n);
    logic [127:0] t;
    t = {x, x} << n;
    return t[127:64];
  endfunction

  function automatic logic [3:0] cr_of(logic [63:0] v, logic so);
    return {v[63], !v[63] && (v != 64'h0), v == 64'h0, so};
  endfunction

  function automatic logic gpr_ok(logic [4:0] r);
    return GPR_DEF[r];
  endfunction

  // pairs live on even indices only
  function automatic logic pair_ok(logic [4:0] r);
    return !r[0] && GPR_DEF[r] && GPR_DEF[r | 5'h01];
  endfunction

  logic [4:0]  f_rs;
  logic [4:0]  f_ra;
  logic [4:0]  f_rb;
  logic [5:0]  f_sh;
  logic [5:0]  f_mb;
  logic [31:0] ui_lo;
  logic [31:0] ui_hi;
  logic [31:0] new_iar;
  logic [3:0]  irq_en;
  logic [3:0]  irq_hit;
  lrr_op_t     dop;
  logic        bad;
  logic [63:0] rot;
  logic [63:0] msk;
  logic [31:0] w32;

  always_comb begin
    st_nxt  = '0;
    f_rs    = req.instr[RS_LSB +: 5];
    f_ra    = req.instr[RA_LSB +: 5];
    f_rb    = req.instr[RB_LSB +: 5];
    f_sh    = {req.instr[SH5_POS], req.instr[RB_LSB +: 5]};
    f_mb    = {req.instr[MB5_POS], req.instr[MB_LSB +: 5]};
    ui_lo   = {16'h0000, req.instr[15:0]};
    ui_hi   = {req.instr[15:0], 16'h0000};
    new_iar = srr_addr_in & IAR_MASK;
    for (int k = 0; k < NIRQ; k++) begin
      irq_en[k] = srr_state_in[IRQ_EN_POS[k]];
    end
    irq_hit = irq_pend & irq_en;
    dop     = req.valid ? decode(req.instr) : OP_NONE;
    rot     = rotl64(req.src_pair, f_sh);
    msk     = '0;
    w32     = '0;
    bad     = 1'b0;
    case (dop)
      OP_ORC:    bad = !(gpr_ok(f_rs) && gpr_ok(f_ra) && gpr_ok(f_rb));
      OP_ORI,
      OP_ORIS:   bad = !(gpr_ok(f_rs) && gpr_ok(f_ra));
      OP_RLDICL,
      OP_RLDICR,
      OP_RLDIMI: bad = !ext_core || !(pair_ok(f_rs) && pair_ok(f_ra));
      default:   bad = 1'b0;
    endcase
    st_nxt.op          = dop;
    st_nxt.res.illegal = bad;
    if (!bad) begin
      case (dop)
        OP_ORC: begin
          w32 = req.src | ~req.src2;
        end
        OP_ORI: begin
          w32 = req.src | ui_lo;
        end
        OP_ORIS: begin
          w32 = req.src | ui_hi;
        end
        OP_RLDICL: begin
          msk = mask64(f_mb, 6'h3f);
        end
        OP_RLDICR: begin
          msk = mask64(6'h00, f_mb);
        end
        OP_RLDIMI: begin
          msk = mask64(f_mb, 6'h3f - f_sh);
        end
        default: begin
          w32 = '0;
        end
      endcase
      if (dop == OP_ORC || dop == OP_ORI || dop == OP_ORIS) begin
        st_nxt.res.gpr_we   = 1'b1;
        st_nxt.res.gpr_idx  = f_ra;
        st_nxt.res.gpr_data = w32;
        // of the or forms only the X-form has a record bit; immediates never touch the condition field
        st_nxt.res.cr0_we = (dop == OP_ORC) && req.instr[RC_POS];
        st_nxt.res.cr0    = cr_of({{32{w32[31]}}, w32}, xer_so);
      end
      if (dop == OP_RLDICL || dop == OP_RLDICR || dop == OP_RLDIMI) begin
        st_nxt.res.pair_we   = 1'b1;
        st_nxt.res.pair_idx  = f_ra;
        // clear forms see a zero destination outside the mask
        st_nxt.res.pair_data = (rot & msk) | ((dop == OP_RLDIMI) ? (req.dst_pair & ~msk) : 64'h0);
        st_nxt.res.cr0_we    = req.instr[RC_POS];
        st_nxt.res.cr0       = cr_of(st_nxt.res.pair_data, xer_so);
      end
      if (dop == OP_RFI) begin
        st_nxt.res.iar_we   = 1'b1;
        st_nxt.res.instruction_address_reg      = new_iar;
        st_nxt.res.wait_enable_bit   = 1'b1;
        st_nxt.res.machine_state_reg      = srr_state_in;
        // debug ram is never a context sync, plain stepping still is
        st_nxt.res.ctx_sync = !rammed;
        if (!halted) begin
          if (irq_hit != 4'h0) begin
            st_nxt.res.int_take = 1'b1;
            st_nxt.res.int_idx  = irq_hit[0] ? 2'h0 : irq_hit[1] ? 2'h1 : irq_hit[2] ? 2'h2 : 2'h3;
            st_nxt.res.save_restore_addr_we  = 1'b1;
            st_nxt.res.save_restore_addr     = new_iar;
            st_nxt.res.save_restore_state_we  = 1'b1;
            st_nxt.res.save_restore_state     = srr_state_in;
          end else if (srr_state_in[WAIT_ENABLE_BIT_POS]) begin
            st_nxt.res.wait_enter = 1'b1;
          end else begin
            st_nxt.res.fetch      = 1'b1;
            st_nxt.res.fetch_addr = new_iar;
          end
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign res = st_r.res;

  // checks on the registered results
  property p_orc_value;
    @(posedge clk) disable iff (rst)
      (st_r.op == OP_ORC && !res.illegal) |-> (res.gpr_we && res.gpr_data == ($past(req.src) | ~$past(req.src2)));
  endproperty
  a_orc_value: assert property (p_orc_value) else $error("or-complement result wrong");

  property p_record;
    @(posedge clk) disable iff (rst)
      (st_r.op == OP_ORC && !res.illegal) |-> (res.cr0_we == $past(req.instr[RC_POS]));
  endproperty
  a_record: assert property (p_record) else $error("condition update does not follow record bit");

  property p_ori_value;
    @(posedge clk) disable iff (rst)
      (st_r.op == OP_ORI && !res.illegal) |->
        (res.gpr_data == ($past(req.src) | {16'h0000, $past(req.instr[15:0])}) && !res.cr0_we);
  endproperty
  a_ori_value: assert property (p_ori_value) else $error("or immediate result wrong");

  property p_oris_value;
    @(posedge clk) disable iff (rst)
      (st_r.op == OP_ORIS && !res.illegal) |->
        (res.gpr_data == ($past(req.src) | {$past(req.instr[15:0]), 16'h0000}) && !res.cr0_we);
  endproperty
  a_oris_value: assert property (p_oris_value) else $error("or immediate shifted result wrong");

  property p_illegal_quiet;
    @(posedge clk) disable iff (rst)
      res.illegal |-> !(res.gpr_we || res.pair_we || res.cr0_we || res.iar_we);
  endproperty
  a_illegal_quiet: assert property (p_illegal_quiet) else $error("illegal op changed state");

  property p_rfi_restore;
    @(posedge clk) disable iff (rst)
      (st_r.op == OP_RFI) |->
        (res.instruction_address_reg == ($past(srr_addr_in) & IAR_MASK) && res.machine_state_reg == $past(srr_state_in) && res.iar_we && res.wait_enable_bit);
  endproperty
  a_rfi_restore: assert property (p_rfi_restore) else $error("return restore wrong");

  property p_halt_quiet;
    @(posedge clk) disable iff (rst)
      (st_r.op == OP_RFI && $past(halted)) |-> !(res.int_take || res.wait_enter || res.fetch || res.save_restore_addr_we);
  endproperty
  a_halt_quiet: assert property (p_halt_quiet) else $error("halted return changed extra state");

  property p_irq_save;
    @(posedge clk) disable iff (rst)
      res.int_take |-> (res.save_restore_addr == res.instruction_address_reg && res.save_restore_state == res.machine_state_reg && !res.fetch && !res.wait_enter);
  endproperty
  a_irq_save: assert property (p_irq_save) else $error("interrupt save registers wrong");

  property p_wait;
    @(posedge clk) disable iff (rst)
      // enables judged from the restored state word, not from the decode path
      (st_r.op == OP_RFI && !$past(halted) &&
        ($past(irq_pend) & {res.machine_state_reg[IRQ_EN_POS[3]], res.machine_state_reg[IRQ_EN_POS[2]],
                            res.machine_state_reg[IRQ_EN_POS[1]], res.machine_state_reg[IRQ_EN_POS[0]]}) == 4'h0) |->
        (res.wait_enter == res.machine_state_reg[WAIT_ENABLE_BIT_POS] && res.fetch == !res.machine_state_reg[WAIT_ENABLE_BIT_POS]);
  endproperty
  a_wait: assert property (p_wait) else $error("wait or fetch choice wrong");

  property p_fetch_addr;
    @(posedge clk) disable iff (rst)
      res.fetch |-> (res.fetch_addr == res.instruction_address_reg && res.fetch_addr[1:0] == 2'b00);
  endproperty
  a_fetch_addr: assert property (p_fetch_addr) else $error("fetch address wrong");

  property p_ram_sync;
    @(posedge clk) disable iff (rst)
      (st_r.op == OP_RFI) |-> (res.ctx_sync == !$past(rammed));
  endproperty
  a_ram_sync: assert property (p_ram_sync) else $error("context sync wrong under ram");

  property p_clrl_mask;
    @(posedge clk) disable iff (rst)
      (st_r.op == OP_RLDICL && !res.illegal) |->
        ((res.pair_data & ~(ONES64 >> {$past(req.instr[MB5_POS]), $past(req.instr[MB_LSB +: 5])})) == 64'h0);
  endproperty
  a_clrl_mask: assert property (p_clrl_mask) else $error("clear left left bits above mask begin");

  property p_base_illegal;
    @(posedge clk) disable iff (rst)
      (req.valid && req.instr[OPC_LSB +: 6] == OPC_RLD && !ext_core && decode(req.instr) != OP_NONE) |=>
        (res.illegal && !res.pair_we);
  endproperty
  a_base_illegal: assert property (p_base_illegal) else $error("base core ran doubleword rotate");

  property p_orc_cr;
    @(posedge clk) disable iff (rst)
      (st_r.op == OP_ORC && res.cr0_we) |->
        (res.cr0 == {res.gpr_data[31], !res.gpr_data[31] && (res.gpr_data != 32'h0),
                     res.gpr_data == 32'h0, $past(xer_so)});
  endproperty
  a_orc_cr: assert property (p_orc_cr) else $error("condition field from or-complement wrong");

  property p_exit_onehot;
    @(posedge clk) disable iff (rst)
      (st_r.op == OP_RFI && !$past(halted)) |-> $onehot({res.int_take, res.wait_enter, res.fetch});
  endproperty
  a_exit_onehot: assert property (p_exit_onehot) else $error("return took no or several exits");

  property p_int_prio;
    @(posedge clk) disable iff (rst)
      (res.int_take && res.int_idx != 2'h0) |-> !($past(irq_pend[0]) && res.machine_state_reg[IRQ_EN_POS[0]]);
  endproperty
  a_int_prio: assert property (p_int_prio) else $error("lower class taken over enabled class zero");

  property p_clrl_keep;
    @(posedge clk) disable iff (rst)
      (st_r.op == OP_RLDICL && !res.illegal) |->
        (((res.pair_data ^ rotl64($past(req.src_pair), $past(f_sh))) & (ONES64 >> $past(f_mb))) == 64'h0);
  endproperty
  a_clrl_keep: assert property (p_clrl_keep) else $error("clear left lost rotated bits");

  property p_clrr_mask;
    @(posedge clk) disable iff (rst)
      (st_r.op == OP_RLDICR && !res.illegal) |->
        ((res.pair_data & ~(ONES64 << (6'h3f - $past(f_mb)))) == 64'h0);
  endproperty
  a_clrr_mask: assert property (p_clrr_mask) else $error("clear right left bits past mask end");

  // every result bit is either the old destination bit or the rotated source bit
  property p_insert_src;
    @(posedge clk) disable iff (rst)
      (st_r.op == OP_RLDIMI && !res.illegal) |->
        (((res.pair_data ^ $past(req.dst_pair)) &
          (res.pair_data ^ rotl64($past(req.src_pair), $past(f_sh)))) == 64'h0);
  endproperty
  a_insert_src: assert property (p_insert_src) else $error("insert took bits from nowhere");

  property p_wrap_ends;
    @(posedge clk) disable iff (rst)
      (st_r.op == OP_RLDIMI && !res.illegal && $past(f_mb) > (6'h3f - $past(f_sh))) |->
        (((res.pair_data ^ rotl64($past(req.src_pair), $past(f_sh))) & 64'h8000000000000001) == 64'h0);
  endproperty
  a_wrap_ends: assert property (p_wrap_ends) else $error("wrapped mask missed an end bit");

  property p_pair_idx;
    @(posedge clk) disable iff (rst)
      res.pair_we |-> (res.pair_idx == $past(req.instr[RA_LSB +: 5]) && !res.pair_idx[0]);
  endproperty
  a_pair_idx: assert property (p_pair_idx) else $error("pair written to wrong register");

  property p_ext_only;
    @(posedge clk) disable iff (rst)
      res.pair_we |-> $past(ext_core);
  endproperty
  a_ext_only: assert property (p_ext_only) else $error("pair written on base variant");

endmodule // lrr_exec

// ---- testbench/test_lrr_exec.sv ----
// self-checking bench for the logic, rotate and return execute slice
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module test_lrr_exec import lrr_pkg::*;;
  // clock and reset
  logic        clk;
  logic        rst;
  // variant, debug and architected state
  logic        ext_core;
  logic        halted;
  logic        rammed;
  logic        xer_so;
  logic [31:0] srr_addr_in;
  logic [31:0] srr_state_in;
  logic [3:0]  irq_pend;
  // request and result
  lrr_req_t    req;
  lrr_res_t    res;
  lrr_res_t    zero_res = '0;
  int          err_count = 0;
  int          samples_checked = 0;

  lrr_exec i_dut (
    .clk          (clk),
    .rst          (rst),
    .ext_core     (ext_core),
    .halted       (halted),
    .rammed       (rammed),
    .xer_so       (xer_so),
    .srr_addr_in  (srr_addr_in),
    .srr_state_in (srr_state_in),
    .irq_pend     (irq_pend),
    .req          (req),
    .res          (res)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic end_sim;
    if (err_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // a hang counts as a mismatch
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    end_sim;
  end

  function automatic logic [63:0] rotl(input logic [63:0] v, input logic [5:0] n);
    return (v << n) | (v >> (7'd64 - {1'b0, n}));
  endfunction

  // result flags from a sign-extended value
  function automatic logic [3:0] crv(input logic [63:0] r, input logic so);
    return {$signed(r) < 0, $signed(r) > 0, r == 64'h0, so};
  endfunction

  // big-endian mask from b to e, wrapping when b is past e
  function automatic logic [63:0] wmask(input logic [5:0] b, input logic [5:0] e);
    logic [63:0] m;
    for (int i = 0; i < 64; i++) begin
      m[63-i] = (b <= e) ? (i >= b && i <= e) : (i >= b || i <= e);
    end
    return m;
  endfunction

  // valid is left high so the next call can follow back to back
  task automatic go(input logic [31:0] ins, input lrr_res_t exp, input string nm);
    req.instr = ins;
    req.valid = 1'b1;
    @(posedge clk);
    #1;
    `CHK(nm, exp, res)
  endtask

  task automatic idle;
    req.valid = 1'b0;
    @(posedge clk);
    #1;
    `CHK("idle", zero_res, res)
  endtask

  task automatic orc_case(input logic [31:0] a, input logic [31:0] b, input logic rc, input logic so);
    lrr_res_t e;
    e = '0;
    req.src = a;
    req.src2 = b;
    xer_so = so;
    e.gpr_we = 1'b1;
    e.gpr_idx = 5'h0b;
    e.gpr_data = a | ~b;
    e.cr0_we = rc;
    // flags are driven even when the record strobe stays low
    e.cr0 = crv({{32{e.gpr_data[31]}}, e.gpr_data}, so);
    go({OPC_X, 5'h03, 5'h0b, 5'h07, XO_ORC, rc}, e, "orc");
  endtask

  task automatic ori_case(input logic [5:0] op, input logic [4:0] rs, input logic [4:0] ra,
                          input logic [15:0] ui, input logic [31:0] a);
    lrr_res_t e;
    e = '0;
    req.src = a;
    xer_so = 1'b1;
    e.gpr_we = 1'b1;
    e.gpr_idx = ra;
    e.gpr_data = a | ((op == OPC_ORIS) ? {ui, 16'h0} : {16'h0, ui});
    e.cr0 = crv({{32{e.gpr_data[31]}}, e.gpr_data}, 1'b1);
    go({op, rs, ra, ui}, e, "ori");
  endtask

  task automatic rfi_case(input logic h, input logic rm, input logic [3:0] pend,
                          input logic [31:0] state, input logic [31:0] addr);
    lrr_res_t   e;
    logic [3:0] en;
    e = '0;
    halted = h;
    rammed = rm;
    irq_pend = pend;
    srr_state_in = state;
    srr_addr_in = addr;
    e.iar_we = 1'b1;
    e.instruction_address_reg = addr & IAR_MASK;
    e.wait_enable_bit = 1'b1;
    e.machine_state_reg = state;
    e.ctx_sync = !rm;
    for (int i = 0; i < NIRQ; i++) begin
      en[i] = pend[i] & state[IRQ_EN_POS[i]];
    end
    if (!h && en != 4'h0) begin
      e.int_take = 1'b1;
      e.int_idx = en[0] ? 2'h0 : en[1] ? 2'h1 : en[2] ? 2'h2 : 2'h3;
      e.save_restore_addr_we = 1'b1;
      e.save_restore_addr = e.instruction_address_reg;
      e.save_restore_state_we = 1'b1;
      e.save_restore_state = state;
    end else if (!h && state[WAIT_ENABLE_BIT_POS]) begin
      e.wait_enter = 1'b1;
    end else if (!h) begin
      e.fetch = 1'b1;
      e.fetch_addr = e.instruction_address_reg;
    end
    go({OPC_XL, 15'h0, XO_RFI, 1'b0}, e, "rfi");
  endtask

  task automatic rld_case(input logic [2:0] sub, input logic [4:0] ds, input logic [4:0] da,
                          input logic [5:0] n, input logic [5:0] mb, input logic rc, input logic ext);
    lrr_res_t    e;
    logic [63:0] r;
    logic [63:0] m;
    e = '0;
    ext_core = ext;
    xer_so = 1'b1;
    r = rotl(req.src_pair, n);
    case (sub)
      SUB_RLDICL: m = ONES64 >> mb;
      SUB_RLDICR: m = ONES64 << (6'd63 - mb);
      default: m = wmask(mb, 6'd63 - n);
    endcase
    if (!ext || ds[0] || da[0]) begin
      e.illegal = 1'b1;
    end else begin
      e.pair_we = 1'b1;
      e.pair_idx = da;
      e.pair_data = (r & m) | ((sub == SUB_RLDIMI) ? (req.dst_pair & ~m) : 64'h0);
      e.cr0_we = rc;
      e.cr0 = crv(e.pair_data, 1'b1);
    end
    go({OPC_RLD, ds, da, n[4:0], mb[4:0], mb[5], sub, n[5], rc}, e, "rld");
  endtask

  // back to back, all three cr0 outcomes, record off with so set
  task automatic t_orc;
    orc_case(32'h0000_00f0, 32'hffff_ff0f, 1'b1, 1'b0);
    orc_case(32'h0000_0000, 32'hffff_ffff, 1'b1, 1'b1);
    orc_case(32'h0000_0001, 32'h7fff_ffff, 1'b1, 1'b0);
    orc_case(32'h1234_0000, 32'h00ff_00ff, 1'b0, 1'b1);
    idle;
  endtask

  task automatic t_ori;
    ori_case(OPC_ORI, 5'h02, 5'h1f, 16'h8001, 32'h1200_0000);
    ori_case(OPC_ORIS, 5'h02, 5'h04, 16'h8001, 32'h0000_0010);
    ori_case(OPC_ORI, 5'h00, 5'h00, 16'h0000, 32'hdead_0001);
    go({6'h05, 26'h0}, zero_res, "unknown");
    idle;
  endtask

  task automatic t_rfi;
    rfi_case(1'b0, 1'b0, 4'h0, 32'h0000_0000, 32'h1234_567b);
    rfi_case(1'b0, 1'b0, 4'h6, 32'h0009_0000, 32'h0000_1002);
    rfi_case(1'b0, 1'b0, 4'hf, 32'h8009_0000, 32'h0000_2001);
    rfi_case(1'b0, 1'b0, 4'h2, 32'h0004_0000, 32'h0000_3003);
    rfi_case(1'b0, 1'b0, 4'h1, 32'h0009_0000, 32'h0000_4000);
    rfi_case(1'b1, 1'b1, 4'hf, 32'h800d_0000, 32'h0000_5001);
    rfi_case(1'b1, 1'b0, 4'hf, 32'h800d_0000, 32'h0000_6002);
    rfi_case(1'b0, 1'b1, 4'h0, 32'h0000_0000, 32'hffff_ffff);
    halted = 1'b0;
    rammed = 1'b0;
    idle;
  endtask

  // sixth bits set, wrap mask, base variant and odd pairs refused
  task automatic t_rld;
    rld_case(SUB_RLDICL, 5'h04, 5'h06, 6'h25, 6'h21, 1'b1, 1'b1);
    rld_case(SUB_RLDICL, 5'h00, 5'h02, 6'h00, 6'h00, 1'b1, 1'b1);
    rld_case(SUB_RLDICR, 5'h08, 5'h0a, 6'h03, 6'h2a, 1'b0, 1'b1);
    rld_case(SUB_RLDICR, 5'h08, 5'h0a, 6'h3f, 6'h3f, 1'b1, 1'b1);
    rld_case(SUB_RLDIMI, 5'h04, 5'h06, 6'h0a, 6'h05, 1'b1, 1'b1);
    rld_case(SUB_RLDIMI, 5'h04, 5'h06, 6'h0a, 6'h3c, 1'b0, 1'b1);
    rld_case(SUB_RLDICL, 5'h04, 5'h06, 6'h25, 6'h21, 1'b1, 1'b0);
    rld_case(SUB_RLDIMI, 5'h04, 5'h07, 6'h01, 6'h00, 1'b0, 1'b1);
    rld_case(SUB_RLDICR, 5'h05, 5'h06, 6'h01, 6'h00, 1'b0, 1'b1);
    idle;
  endtask

  initial begin
    rst = 1'b1;
    ext_core = 1'b0;
    halted = 1'b0;
    rammed = 1'b0;
    xer_so = 1'b0;
    srr_addr_in = 32'h0;
    srr_state_in = 32'h0;
    irq_pend = 4'h0;
    req = '0;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    `CHK("reset", zero_res, res)
    req.src_pair = 64'h8123_4567_89ab_cdef;
    req.dst_pair = 64'h0ff0_5aa5_c33c_9669;
    // or forms run first with the base variant selected
    t_orc;
    t_ori;
    t_rfi;
    t_rld;
    end_sim;
  end
endmodule // test_lrr_exec
